// *** hw/efr_pkg.sv ***
// Constants, types and helpers for the Ethernet frame reflector.
// Assumes one 100 MHz clock, byte-wide frame streams and a plain register port.
//
// Operation
// - When reflection is on, resend each accepted frame with MAC and/or IP addresses swapped.
// - Reflection runs full duplex only; half duplex is withdrawn one cycle after reflection is enabled.
// - Frames with a multicast or broadcast destination are dropped, except ARP and ping requests to our address.
// - Output gap follows processing latency; no minimum gap is enforced.
// - ARP and ping requests are answered from the configured reply MAC and IP.
// - With VLAN matching, tag depth and every tag identifier must match the setup.
// - Errored frames are counted, compared with a limit, pass/fail and exceed count kept.
package efr_pkg;

  localparam int unsigned MEM_DEPTH = 2048;
  localparam logic [10:0] MIN_LEN   = 11'h040;
  localparam logic [10:0] MAX_LEN   = 11'h60E;
  localparam logic [10:0] FCS_BYTES = 11'h004;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_MAC_LO  = 4'h1;
  localparam logic [3:0] REG_MAC_HI  = 4'h2;
  localparam logic [3:0] REG_IP      = 4'h3;
  localparam logic [3:0] REG_VID0    = 4'h4;
  localparam logic [3:0] REG_VID3    = 4'h7;
  localparam logic [3:0] REG_THRESH  = 4'h8;
  localparam logic [3:0] REG_ERRCNT  = 4'h9;
  localparam logic [3:0] REG_EXCEED  = 4'hA;
  localparam logic [3:0] REG_STATUS  = 4'hB;
  localparam logic [3:0] REG_IRQ_CLR = 4'hC;
  localparam logic [3:0] REG_IRQ_EN  = 4'hD;

  // Control bits
  localparam int CB_REFLECT  = 0;
  localparam int CB_SWAP_MAC = 1;
  localparam int CB_SWAP_IP  = 2;
  localparam int CB_ARP      = 3;
  localparam int CB_PING     = 4;
  localparam int CB_VLAN     = 5;
  localparam int CB_THR      = 6;
  localparam int CB_HDX      = 7;
  localparam int CTRL_W      = 12;

  // Status / interrupt bits
  localparam int ST_REFLECT = 0;
  localparam int ST_ANSWER  = 1;
  localparam int ST_FILTER  = 2;
  localparam int ST_ERROR   = 3;
  localparam int ST_THRESH  = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_W       = 6;

  // Frame layout
  localparam logic [10:0] OFS_SA     = 11'h006;
  localparam logic [10:0] OFS_TYPE   = 11'h00C;
  localparam logic [10:0] HDR_BYTES  = 11'h01C;
  localparam logic [15:0] ETH_IPV4   = 16'h0800;
  localparam logic [15:0] ETH_ARP    = 16'h0806;
  localparam logic [15:0] TPID_C     = 16'h8100;
  localparam logic [15:0] TPID_S     = 16'h88A8;
  localparam logic [3:0]  VLAN_MAX   = 4'h8;
  localparam logic [4:0]  H_VER      = 5'h00;
  localparam logic [4:0]  H_PROTO    = 5'h09;
  localparam logic [4:0]  H_SIP      = 5'h0C;
  localparam logic [4:0]  H_DIP      = 5'h10;
  localparam logic [4:0]  H_IPEND    = 5'h14;
  localparam logic [4:0]  H_ICMP_CS  = 5'h16;
  localparam logic [4:0]  A_OPER     = 5'h07;
  localparam logic [4:0]  A_SHA      = 5'h08;
  localparam logic [4:0]  A_SPA      = 5'h0E;
  localparam logic [4:0]  A_THA      = 5'h12;
  localparam logic [4:0]  A_TPA      = 5'h18;
  localparam logic [4:0]  A_MOVE     = 5'h0A;
  localparam logic [4:0]  IP_WORD    = 5'h04;
  localparam logic [7:0]  IPV4_IHL5  = 8'h45;
  localparam logic [7:0]  PROTO_ICMP = 8'h01;
  localparam logic [7:0]  ICMP_REQ   = 8'h08;
  localparam logic [7:0]  ICMP_REP   = 8'h00;
  localparam logic [15:0] ARP_REQ    = 16'h0001;
  localparam logic [7:0]  ARP_REP_LO = 8'h02;
  localparam logic [15:0] ICMP_ADJ   = 16'h0800;

  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [1:0] {KIND_REFL = 2'h0, KIND_ARP = 2'h1, KIND_PING = 2'h2} efr_kind_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_DATA = 3'b010, TX_FCS = 3'b100} efr_tx_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       error;
  } efr_byte_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } efr_bus_req_t;

  // Reflected CRC-32, one byte at a time
  function automatic logic [31:0] efr_crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : efr_crc_byte

endpackage : efr_pkg

// *** hw/efr_reflector.sv ***
// Ethernet frame reflector: stores a received frame, decides, then resends it edited.
// Assumes byte streams synchronous to i_mclk and a link partner on a full-duplex port.
`timescale 1ns/1ps
`default_nettype none
module efr_reflector (
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire efr_pkg::efr_byte_t    i_rx,
  output var  efr_pkg::efr_byte_t    o_tx,
  input  wire efr_pkg::efr_bus_req_t i_bus,
  output var  logic [31:0]           o_rdata,
  output var  logic                  o_half_duplex_operation,
  output var  logic                  o_irq
);
  import efr_pkg::*;

  logic [CTRL_W-1:0]    ctrl_q;
  logic [47:0]          mac_q;
  logic [31:0]          ip_q;
  logic [11:0]          vid_q [0:7];
  logic [31:0]          thresh_q;
  logic [31:0]          err_cnt_q;
  logic [30:0]          exceed_q;
  logic                 fail_q;
  logic [ST_W-1:0]      status_q;
  logic [ST_W-1:0]      irq_en_q;

  logic [7:0]           mem [0:MEM_DEPTH-1];
  logic [10:0]          rx_idx_q;
  logic [31:0]          rx_crc_q;
  logic                 in_tags_q;
  logic [1:0]           sub_q;
  logic [3:0]           tag_cnt_q;
  logic                 vid_ok_q;
  logic [7:0]           type_hi_q;
  logic [15:0]          etype_q;
  logic [10:0]          base_q;
  logic [3:0]           vid_hi_q;
  logic                 toolong_q;
  logic                 drop_q;
  logic [7:0]           hdr_q [0:27];
  logic [7:0]           da_q [0:5];
  logic [7:0]           sa_q [0:5];

  efr_tx_state_t        tx_state_q;
  efr_kind_t            tx_kind_q;
  logic [10:0]          tx_idx_q;
  logic [10:0]          tx_len_q;
  logic [10:0]          tx_base_q;
  logic                 tx_ipv4_q;
  logic [31:0]          tx_crc_q;
  logic [1:0]           fidx_q;

  function automatic logic [7:0] pick_byte(input logic [47:0] v, input logic [2:0] k);
    return v[8*(5-k) +: 8];
  endfunction : pick_byte

  // Receive side decisions, all valid in the cycle of the last byte
  logic        rx_end;
  logic        tx_busy;
  logic        rx_wr;
  logic [31:0] rx_crc_d;
  logic [10:0] rx_len;
  logic        rx_bad;
  logic        overrun;
  logic        is_group;
  logic        vlan_pass;
  logic        is_arp;
  logic        is_ping;
  logic        go;
  logic        err_clr;
  logic        ev_thresh;
  logic [ST_W-1:0] ev;

  assign tx_busy   = tx_state_q != TX_IDLE;
  assign rx_end    = i_rx.valid && i_rx.last;
  // A frame that starts while the single buffer drains is lost whole, never half-stored
  assign rx_wr     = !tx_busy && !drop_q && !toolong_q && rx_idx_q != MAX_LEN;
  assign rx_crc_d  = efr_crc_byte((rx_idx_q == 11'h000) ? CRC_INIT : rx_crc_q, i_rx.data);
  assign rx_len    = rx_idx_q + 11'h001;
  assign rx_bad    = i_rx.error || rx_crc_d != CRC_RESIDUE || rx_len < MIN_LEN ||
                     toolong_q || rx_idx_q == MAX_LEN;
  assign overrun   = tx_busy || drop_q;
  assign is_group  = da_q[0][0];
  assign vlan_pass = !ctrl_q[CB_VLAN] || (vid_ok_q && tag_cnt_q == ctrl_q[11:8]);
  assign is_arp    = ctrl_q[CB_ARP] && etype_q == ETH_ARP &&
                     {hdr_q[A_OPER-5'h01], hdr_q[A_OPER]} == ARP_REQ &&
                     {hdr_q[A_TPA], hdr_q[A_TPA+5'h01], hdr_q[A_TPA+5'h02], hdr_q[A_TPA+5'h03]} == ip_q;
  assign is_ping   = ctrl_q[CB_PING] && etype_q == ETH_IPV4 && hdr_q[H_VER] == IPV4_IHL5 &&
                     hdr_q[H_PROTO] == PROTO_ICMP && hdr_q[H_IPEND] == ICMP_REQ &&
                     {hdr_q[H_DIP], hdr_q[H_DIP+5'h01], hdr_q[H_DIP+5'h02], hdr_q[H_DIP+5'h03]} == ip_q;
  // Group addresses are dropped; a broadcast ARP request to our address is still answered
  assign go        = rx_end && ctrl_q[CB_REFLECT] && !rx_bad && !overrun && !in_tags_q &&
                     vlan_pass && (is_arp || is_ping || !is_group);
  assign err_clr   = i_bus.wr && i_bus.addr == REG_ERRCNT;
  assign ev_thresh = rx_end && rx_bad && ctrl_q[CB_THR] && err_cnt_q >= thresh_q;

  always_comb begin
    ev              = '0;
    ev[ST_REFLECT]  = go && !(is_arp || is_ping);
    ev[ST_ANSWER]   = go && (is_arp || is_ping);
    ev[ST_FILTER]   = rx_end && ctrl_q[CB_REFLECT] && !rx_bad && !overrun && !go;
    ev[ST_ERROR]    = rx_end && rx_bad;
    ev[ST_THRESH]   = ev_thresh;
    ev[ST_OVERRUN]  = rx_end && overrun;
  end

  // Header parser: walks the tag stack and finds the layer-3 start
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rx_idx_q  <= '0;
      rx_crc_q  <= CRC_INIT;
      in_tags_q <= 1'b1;
      sub_q     <= '0;
      tag_cnt_q <= '0;
      vid_ok_q  <= 1'b1;
      type_hi_q <= '0;
      etype_q   <= '0;
      base_q    <= '0;
      vid_hi_q  <= '0;
      toolong_q <= 1'b0;
      drop_q    <= 1'b0;
    end else if (i_rx.valid) begin
      rx_crc_q <= rx_crc_d;
      if (i_rx.last) begin
        rx_idx_q  <= '0;
        in_tags_q <= 1'b1;
        sub_q     <= '0;
        tag_cnt_q <= '0;
        vid_ok_q  <= 1'b1;
        toolong_q <= 1'b0;
        drop_q    <= 1'b0;
      end else begin
        if (tx_busy) begin
          drop_q <= 1'b1;
        end
        if (rx_idx_q != MAX_LEN) begin
          rx_idx_q <= rx_idx_q + 11'h001;
        end else begin
          toolong_q <= 1'b1;
        end
        if (in_tags_q && rx_idx_q >= OFS_TYPE) begin
          sub_q <= sub_q + 2'h1;
          case (sub_q)
            2'h0: begin
              type_hi_q <= i_rx.data;
            end
            2'h1: begin
              if (({type_hi_q, i_rx.data} == TPID_C || {type_hi_q, i_rx.data} == TPID_S)) begin
                if (tag_cnt_q == VLAN_MAX) begin
                  vid_ok_q  <= 1'b0;
                  in_tags_q <= 1'b0;
                end
              end else begin
                in_tags_q <= 1'b0;
                etype_q   <= {type_hi_q, i_rx.data};
                base_q    <= rx_idx_q + 11'h001;
              end
            end
            2'h2: begin
              vid_hi_q <= i_rx.data[3:0];
            end
            default: begin
              if ({vid_hi_q, i_rx.data} != vid_q[tag_cnt_q[2:0]]) begin
                vid_ok_q <= 1'b0;
              end
              tag_cnt_q <= tag_cnt_q + 4'h1;
            end
          endcase
        end
      end
    end
  end

  // Frame store and captured address fields
  always_ff @(posedge i_mclk) begin
    if (i_rx.valid && rx_wr) begin
      mem[rx_idx_q] <= i_rx.data;
      if (rx_idx_q < OFS_SA) begin
        da_q[rx_idx_q[2:0]] <= i_rx.data;
      end else if (rx_idx_q < OFS_TYPE) begin
        sa_q[3'(rx_idx_q - OFS_SA)] <= i_rx.data;
      end
      if (!in_tags_q && rx_idx_q >= base_q && (rx_idx_q - base_q) < HDR_BYTES) begin
        hdr_q[5'(rx_idx_q - base_q)] <= i_rx.data;
      end
    end
  end

  // Outgoing byte with the edits of the chosen kind applied
  logic [10:0] rel;
  logic [4:0]  r5;
  logic [16:0] cs_sum;
  logic [15:0] cs_new;
  logic [7:0]  tx_byte;
  logic        tx_ans;

  always_comb begin
    rel     = tx_idx_q - tx_base_q;
    r5      = rel[4:0];
    tx_ans  = tx_kind_q != KIND_REFL;
    // Only the type byte changes, so the echo checksum is adjusted, not recomputed
    cs_sum  = {1'b0, hdr_q[H_ICMP_CS], hdr_q[H_ICMP_CS+5'h01]} + {1'b0, ICMP_ADJ};
    cs_new  = cs_sum[15:0] + {15'h0000, cs_sum[16]};
    tx_byte = mem[tx_idx_q];
    if (tx_idx_q < OFS_SA) begin
      if (tx_ans || ctrl_q[CB_SWAP_MAC]) begin
        tx_byte = sa_q[tx_idx_q[2:0]];
      end
    end else if (tx_idx_q < OFS_TYPE) begin
      if (tx_ans) begin
        tx_byte = pick_byte(mac_q, 3'(tx_idx_q - OFS_SA));
      end else if (ctrl_q[CB_SWAP_MAC]) begin
        tx_byte = da_q[3'(tx_idx_q - OFS_SA)];
      end
    end else if (tx_idx_q >= tx_base_q && rel < HDR_BYTES) begin
      case (tx_kind_q)
        KIND_PING: begin
          // Source becomes our address, which equals the old destination: IP checksum holds
          if (r5 >= H_SIP && r5 < H_DIP) begin
            tx_byte = pick_byte({16'h0000, ip_q}, 3'(r5 - H_SIP + 5'h02));
          end else if (r5 >= H_DIP && r5 < H_IPEND) begin
            tx_byte = hdr_q[r5 - IP_WORD];
          end else if (r5 == H_IPEND) begin
            tx_byte = ICMP_REP;
          end else if (r5 == H_ICMP_CS) begin
            tx_byte = cs_new[15:8];
          end else if (r5 == H_ICMP_CS + 5'h01) begin
            tx_byte = cs_new[7:0];
          end
        end
        KIND_ARP: begin
          if (r5 == A_OPER) begin
            tx_byte = ARP_REP_LO;
          end else if (r5 >= A_SHA && r5 < A_SPA) begin
            tx_byte = pick_byte(mac_q, 3'(r5 - A_SHA));
          end else if (r5 >= A_SPA && r5 < A_THA) begin
            tx_byte = pick_byte({16'h0000, ip_q}, 3'(r5 - A_SPA + 5'h02));
          end else if (r5 >= A_THA) begin
            tx_byte = hdr_q[r5 - A_MOVE];
          end
        end
        default: begin
          // Swapping two words leaves the one's-complement header sum unchanged
          if (ctrl_q[CB_SWAP_IP] && tx_ipv4_q) begin
            if (r5 >= H_SIP && r5 < H_DIP) begin
              tx_byte = hdr_q[r5 + IP_WORD];
            end else if (r5 >= H_DIP && r5 < H_IPEND) begin
              tx_byte = hdr_q[r5 - IP_WORD];
            end
          end
        end
      endcase
    end
  end

  // Transmit sequencer; fresh FCS over the edited bytes
  logic [31:0] fcs_word;
  assign fcs_word = ~tx_crc_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tx_state_q <= TX_IDLE;
      tx_kind_q  <= KIND_REFL;
      tx_idx_q   <= '0;
      tx_len_q   <= '0;
      tx_base_q  <= '0;
      tx_ipv4_q  <= 1'b0;
      tx_crc_q   <= CRC_INIT;
      fidx_q     <= '0;
      o_tx       <= '0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          o_tx <= '0;
          // Starts as soon as the frame is judged; no gap timer, so gaps may be short
          if (go) begin
            tx_state_q <= TX_DATA;
            tx_kind_q  <= is_arp ? KIND_ARP : (is_ping ? KIND_PING : KIND_REFL);
            tx_idx_q   <= '0;
            tx_len_q   <= rx_len - FCS_BYTES;
            tx_base_q  <= base_q;
            tx_ipv4_q  <= etype_q == ETH_IPV4;
            tx_crc_q   <= CRC_INIT;
          end
        end
        TX_DATA: begin
          o_tx.valid <= 1'b1;
          o_tx.data  <= tx_byte;
          o_tx.last  <= 1'b0;
          o_tx.error <= 1'b0;
          tx_crc_q   <= efr_crc_byte(tx_crc_q, tx_byte);
          tx_idx_q   <= tx_idx_q + 11'h001;
          if (tx_idx_q == tx_len_q - 11'h001) begin
            tx_state_q <= TX_FCS;
            fidx_q     <= '0;
          end
        end
        TX_FCS: begin
          o_tx.valid <= 1'b1;
          o_tx.data  <= fcs_word[{fidx_q, 3'b000} +: 8];
          o_tx.last  <= fidx_q == 2'h3;
          o_tx.error <= 1'b0;
          fidx_q     <= fidx_q + 2'h1;
          if (fidx_q == 2'h3) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Configuration registers and read port
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q   <= '0;
      mac_q    <= '0;
      ip_q     <= '0;
      thresh_q <= '0;
      irq_en_q <= '0;
      o_rdata  <= '0;
      for (int i = 0; i < 8; i++) begin
        vid_q[i] <= '0;
      end
    end else begin
      if (i_bus.wr) begin
        if (i_bus.addr == REG_CTRL) begin
          ctrl_q <= i_bus.wdata[CTRL_W-1:0];
        end else if (i_bus.addr == REG_MAC_LO) begin
          mac_q[31:0] <= i_bus.wdata;
        end else if (i_bus.addr == REG_MAC_HI) begin
          mac_q[47:32] <= i_bus.wdata[15:0];
        end else if (i_bus.addr == REG_IP) begin
          ip_q <= i_bus.wdata;
        end else if (i_bus.addr >= REG_VID0 && i_bus.addr <= REG_VID3) begin
          vid_q[{i_bus.addr[1:0], 1'b0}] <= i_bus.wdata[11:0];
          vid_q[{i_bus.addr[1:0], 1'b1}] <= i_bus.wdata[27:16];
        end else if (i_bus.addr == REG_THRESH) begin
          thresh_q <= i_bus.wdata;
        end else if (i_bus.addr == REG_IRQ_EN) begin
          irq_en_q <= i_bus.wdata[ST_W-1:0];
        end
      end
      o_rdata <= '0;
      if (i_bus.rd) begin
        if (i_bus.addr == REG_CTRL) begin
          o_rdata <= {20'h00000, ctrl_q};
        end else if (i_bus.addr == REG_MAC_LO) begin
          o_rdata <= mac_q[31:0];
        end else if (i_bus.addr == REG_MAC_HI) begin
          o_rdata <= {16'h0000, mac_q[47:32]};
        end else if (i_bus.addr == REG_IP) begin
          o_rdata <= ip_q;
        end else if (i_bus.addr >= REG_VID0 && i_bus.addr <= REG_VID3) begin
          o_rdata <= {4'h0, vid_q[{i_bus.addr[1:0], 1'b1}], 4'h0, vid_q[{i_bus.addr[1:0], 1'b0}]};
        end else if (i_bus.addr == REG_THRESH) begin
          o_rdata <= thresh_q;
        end else if (i_bus.addr == REG_ERRCNT) begin
          o_rdata <= err_cnt_q;
        end else if (i_bus.addr == REG_EXCEED) begin
          o_rdata <= {fail_q, exceed_q};
        end else if (i_bus.addr == REG_STATUS) begin
          o_rdata <= {26'h0000000, status_q};
        end else if (i_bus.addr == REG_IRQ_EN) begin
          o_rdata <= {26'h0000000, irq_en_q};
        end
      end
    end
  end

  // Half duplex can only be requested while reflection is off
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_half_duplex_operation <= 1'b0;
    end else begin
      o_half_duplex_operation <= ctrl_q[CB_HDX] && !ctrl_q[CB_REFLECT];
    end
  end

  // Error monitoring; a clear in the same cycle as an error still counts that error
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      err_cnt_q <= '0;
      exceed_q  <= '0;
      fail_q    <= 1'b0;
    end else begin
      err_cnt_q <= (err_clr ? 32'h00000000 : err_cnt_q) + {31'h00000000, ev[ST_ERROR]};
      exceed_q  <= (err_clr ? 31'h00000000 : exceed_q) + {30'h00000000, ev_thresh};
      fail_q    <= (fail_q && !err_clr) || ev_thresh;
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      status_q <= '0;
      o_irq    <= 1'b0;
    end else begin
      status_q <= (status_q & ~((i_bus.wr && i_bus.addr == REG_IRQ_CLR) ? i_bus.wdata[ST_W-1:0] : '0)) | ev;
      o_irq    <= |(status_q & irq_en_q);
    end
  end

  a_hdx_blocked: assert property (@(posedge i_mclk) disable iff (i_reset)
    ctrl_q[CB_REFLECT] |=> !o_half_duplex_operation) else $error("half duplex offered while reflecting");
  a_group_dropped: assert property (@(posedge i_mclk) disable iff (i_reset)
    rx_end && is_group && !is_arp && !is_ping && !tx_busy |=> tx_state_q == TX_IDLE)
    else $error("group-addressed frame reflected");
  a_reflect_out: assert property (@(posedge i_mclk) disable iff (i_reset)
    go |-> ##2 o_tx.valid && !o_tx.last) else $error("accepted frame not resent");
  a_no_gap_wait: assert property (@(posedge i_mclk) disable iff (i_reset)
    go |=> tx_state_q == TX_DATA && tx_idx_q == 11'h000) else $error("transmit start delayed");
  a_fcs_tail: assert property (@(posedge i_mclk) disable iff (i_reset)
    tx_state_q == TX_DATA && tx_idx_q == tx_len_q - 11'h001 |=> ##4 o_tx.valid && o_tx.last)
    else $error("frame check sequence not appended");
  a_answer_src: assert property (@(posedge i_mclk) disable iff (i_reset)
    tx_state_q == TX_DATA && tx_kind_q != KIND_REFL && tx_idx_q == OFS_SA |=> o_tx.data == mac_q[47:40])
    else $error("reply source address wrong");
  a_vlan_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
    rx_end && ctrl_q[CB_VLAN] && tag_cnt_q != ctrl_q[11:8] |-> !go) else $error("tag depth mismatch accepted");
  a_err_count: assert property (@(posedge i_mclk) disable iff (i_reset)
    ev[ST_ERROR] && !err_clr |=> err_cnt_q == $past(err_cnt_q) + 32'h00000001)
    else $error("errored frame not counted");
  a_thresh_fail: assert property (@(posedge i_mclk) disable iff (i_reset)
    ev_thresh |=> fail_q && exceed_q != 31'h00000000) else $error("threshold crossing not flagged");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (i_reset)
    |(status_q & irq_en_q) |=> o_irq) else $error("interrupt not raised");

endmodule : efr_reflector
`default_nettype wire

// *** sim/efr_peer.sv ***
// Link partner model: sends whole frames with a valid, or on request corrupted, FCS on the receive stream.
// Assumes the bench fills f[] and calls send only between frames.
`timescale 1ns/1ps
`default_nettype none
module efr_peer (
  input  wire logic          i_mclk,
  output var  efr_pkg::efr_byte_t o_rx
);
  import efr_pkg::*;
  logic [7:0] f [0:1599];

  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return c;
  endfunction : crc_upd

  // A bad flag flips one FCS bit, the only fault the bench commands
  task automatic send(input int n, input logic bad);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++) begin
      c = crc_upd(c, f[i]);
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) begin
      f[n + i] = c[8 * i +: 8];
    end
    for (int i = 0; i < n + 4; i++) begin
      @(posedge i_mclk);
      o_rx <= '{1'b1, f[i], i == n + 3, 1'b0};
    end
    // Idle data shows the inverse so a stale byte is never mistaken for live data
    @(posedge i_mclk);
    o_rx <= '{1'b0, ~f[n + 3], 1'b0, 1'b0};
  endtask : send

  initial o_rx = '0;
endmodule : efr_peer
`default_nettype wire

// *** sim/test_ethernet_frame_reflector.sv ***
// Self-checking bench for the frame reflector: register port plus frame traffic.
// Assumes the partner model efr_peer drives the receive stream.
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_frame_reflector;
  import efr_pkg::*;
  logic         mclk;
  logic         rst;
  efr_byte_t    rx;
  efr_byte_t    tx;
  efr_bus_req_t bus;
  logic [31:0]  rdata;
  logic         half_duplex_operation;
  logic         irq;
  int           failures;
  int           check_count;
  logic [7:0]   got [$];

  efr_reflector u_dut (.i_mclk(mclk), .i_reset(rst), .i_rx(rx), .o_tx(tx), .i_bus(bus), .o_rdata(rdata),
                       .o_half_duplex_operation(half_duplex_operation), .o_irq(irq));
  efr_peer u_peer (.i_mclk(mclk), .o_rx(rx));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run;
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge mclk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  // Bounded: an empty queue after lim cycles means nothing was sent
  task automatic grab(input int lim);
    got.delete();
    for (int i = 0; i < lim; i++) begin
      @(posedge mclk);
      #1;
      if (tx.valid === 1'b1) got.push_back(tx.data);
      if (tx.valid === 1'b1 && tx.last === 1'b1) return;
    end
  endtask : grab

  task automatic txfr(input int n, input logic bad);
    fork
      u_peer.send(n, bad);
      grab(2 * n + 20);
    join
  endtask : txfr

  function automatic logic [31:0] crc_all();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (got[i]) c = u_peer.crc_upd(c, got[i]);
    return c;
  endfunction : crc_all

  function automatic int refl_src(input int i);
    if (i < 12) return (i + 6) % 12;
    if (i < 26 || i > 33) return i;
    return (i < 30) ? i + 4 : i - 4;
  endfunction : refl_src

  // Type 8 becomes 0, so the echo checksum rises by 0x0800 with the carry wrapped
  function automatic logic [15:0] ping_cs(input logic [7:0] hi, input logic [7:0] lo);
    logic [16:0] s;
    s = {1'b0, hi, lo} + 17'h00800;
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ping_cs

  initial begin
    logic [31:0] d;
    logic [47:0] mac;
    logic [31:0] ip;
    int          n;
    rst = 1'b1;
    bus = '0;
    failures = 0;
    check_count = 0;
    d = $urandom(91);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_STATUS, d);
    check(d, 32'h00000000);
    rd(4'hE, d);
    check(d, 32'h00000000);
    wr(REG_CTRL, 32'h00000080);
    @(posedge mclk);
    #1 check(half_duplex_operation, 1'b1);
    mac = {16'($urandom), $urandom};
    ip = $urandom;
    wr(REG_MAC_LO, mac[31:0]);
    wr(REG_MAC_HI, {16'h0000, mac[47:32]});
    wr(REG_IP, ip);
    wr(REG_IRQ_EN, 32'h00000001);
    wr(REG_CTRL, 32'h000000DF);
    @(posedge mclk);
    #1 check(half_duplex_operation, 1'b0);
    // Unicast IPv4 reflect, multicast drop, bad FCS over threshold, VLAN depth mismatch, VLAN match
    for (int k = 0; k < 5; k++) begin
      n = (k == 0) ? 60 + $urandom % 100 : 60;
      for (int i = 0; i < n; i++) u_peer.f[i] = 8'($urandom);
      u_peer.f[0][0] = (k == 1);
      {u_peer.f[12], u_peer.f[13]} = 16'h0800;
      if (k == 3) wr(REG_CTRL, 32'h00000123);
      if (k == 3) wr(REG_VID0, 32'h00000123);
      if (k == 4) {u_peer.f[12], u_peer.f[13], u_peer.f[14], u_peer.f[15], u_peer.f[16]} = 40'h8100012312;
      txfr(n, k == 2);
      check(got.size(), (k == 0 || k == 4) ? n + 4 : 0);
      if (k == 0 && got.size() == n + 4) begin
        for (int i = 0; i < n; i++) check(got[i], u_peer.f[refl_src(i)]);
        check(crc_all(), CRC_RESIDUE);
        check(irq, 1'b1);
        wr(REG_IRQ_CLR, 32'h00000001);
        @(posedge mclk);
        #1 check(irq, 1'b0);
      end
    end
    rd(REG_STATUS, d);
    check(d & 32'h0000001C, 32'h0000001C);
    rd(REG_ERRCNT, d);
    check(d, 32'h00000001);
    rd(REG_EXCEED, d);
    check(d, 32'h80000001);
    wr(REG_ERRCNT, 32'h00000000);
    rd(REG_EXCEED, d);
    check(d, 32'h00000000);
    // Broadcast ARP request for our address
    wr(REG_CTRL, 32'h0000001B);
    for (int i = 0; i < 60; i++) u_peer.f[i] = (i < 6) ? 8'hFF : 8'h00;
    for (int i = 6; i < 12; i++) u_peer.f[i] = 8'($urandom) & 8'hFE;
    for (int i = 0; i < 8; i++) u_peer.f[12 + i] = 8'(64'h0806000108000604 >> (56 - 8 * i));
    u_peer.f[21] = 8'h01;
    for (int i = 0; i < 6; i++) u_peer.f[22 + i] = u_peer.f[6 + i];
    for (int i = 0; i < 4; i++) u_peer.f[38 + i] = ip[31 - 8 * i -: 8];
    txfr(60, 1'b0);
    check(got.size(), 64);
    if (got.size() == 64) begin
      for (int i = 0; i < 6; i++) check(got[i], u_peer.f[6 + i]);
      for (int i = 0; i < 6; i++) check(got[6 + i], mac[47 - 8 * i -: 8]);
      for (int i = 0; i < 4; i++) check(got[28 + i], ip[31 - 8 * i -: 8]);
      check(got[21], 8'h02);
      check(crc_all(), CRC_RESIDUE);
    end
    // Unicast ping request for our address
    for (int i = 0; i < 60; i++) u_peer.f[i] = 8'($urandom);
    u_peer.f[0][0] = 1'b0;
    {u_peer.f[12], u_peer.f[13], u_peer.f[14], u_peer.f[23], u_peer.f[34]} = 40'h0800450108;
    for (int i = 0; i < 4; i++) u_peer.f[30 + i] = ip[31 - 8 * i -: 8];
    txfr(60, 1'b0);
    check(got.size(), 64);
    if (got.size() == 64) begin
      check(got[0], u_peer.f[6]);
      for (int i = 0; i < 4; i++) check(got[26 + i], ip[31 - 8 * i -: 8]);
      for (int i = 0; i < 4; i++) check(got[30 + i], u_peer.f[26 + i]);
      check({got[34], got[36], got[37]}, {8'h00, ping_cs(u_peer.f[36], u_peer.f[37])});
      check(crc_all(), CRC_RESIDUE);
    end
    complete_run();
  end
endmodule : test_ethernet_frame_reflector
`default_nettype wire
